/* File: design/pgdt_map.vh */
// Register offsets, field positions, codes and reset values of the timer pair
`ifndef PGDT_MAP_VH
`define PGDT_MAP_VH

// Byte offsets, one aligned 32-bit word per register
`define PGDT_OFF_SHORT_CTRL   6'h00
`define PGDT_OFF_SHARED_CTRL  6'h04
`define PGDT_OFF_LONG_CTRL    6'h08
`define PGDT_OFF_SHORT_RLD_HI 6'h0C
`define PGDT_OFF_SHORT_RLD_LO 6'h10
`define PGDT_OFF_LONG_RLD_UP  6'h14
`define PGDT_OFF_LONG_RLD_LO  6'h18
`define PGDT_OFF_SHORT_CAP_R  6'h1C
`define PGDT_OFF_SHORT_CAP_F  6'h20
`define PGDT_OFF_LONG_CAP_UP  6'h24
`define PGDT_OFF_LONG_CAP_LO  6'h28

// Per-timer control field positions (short and long control alike)
`define PGDT_B_ENABLE   7
`define PGDT_B_SINGLE   6
`define PGDT_B_TIMEOUT  5
`define PGDT_B_CLK_HI   4
`define PGDT_B_CLK_LO   3
`define PGDT_B_CAP_MASK 2
`define PGDT_B_TO_MASK  1
`define PGDT_B_PIN_EN   0

// Shared control field positions
`define PGDT_B_MODE     7
`define PGDT_B_PIN_SEL  6
`define PGDT_B_EDGE_HI  5
`define PGDT_B_EDGE_LO  4
`define PGDT_B_SUB_HI   3
`define PGDT_B_SUB_LO   2
`define PGDT_B_INIT8    1
`define PGDT_B_INIT16   0

// Transmit submode codes
`define PGDT_SUB_NORMAL 2'h0
`define PGDT_SUB_PPONG  2'h1
`define PGDT_SUB_FORCE0 2'h2
`define PGDT_SUB_FORCE1 2'h3

// Edge select codes
`define PGDT_EDGE_RISE  2'h0
`define PGDT_EDGE_FALL  2'h1

// Output combine codes
`define PGDT_LOG_AND    2'h0
`define PGDT_LOG_OR     2'h1
`define PGDT_LOG_NOR    2'h2

// Glitch filter: count of extra stable cycles before the level is taken
`define PGDT_FLT_4      4'h3
`define PGDT_FLT_8      4'h7
`define PGDT_FLT_16     4'hF

// Counter constants and reset values
`define PGDT_ONES8      8'hFF
`define PGDT_ONES16     16'hFFFF
`define PGDT_ONE8       8'h01
`define PGDT_ONE16      16'h0001
`define PGDT_RST8       8'h00
`define PGDT_RST16      16'h0000

`endif

/* File: design/pgdt_timers.v */
// Short and long down-counter pair with waveform and demodulation modes
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "pgdt_map.vh"

module pgdt_timers (
  input  wire        clk_i,             // System clock, 125 MHz
  input  wire        resetn_i,          // Asynchronous reset, active low
  input  wire [5:0]  avs_address_i,     // Avalon byte address
  input  wire        avs_read_i,        // Avalon read request
  input  wire        avs_write_i,       // Avalon write request
  input  wire [31:0] avs_writedata_i,   // Avalon write data
  input  wire [3:0]  avs_byteenable_i,  // Avalon byte enables
  output wire [31:0] avs_readdata_o,    // Avalon read data
  output wire        avs_waitrequest_o, // Avalon wait request
  input  wire        input_pin_a_i,     // Demodulator input pin a
  input  wire        input_pin_b_i,     // Demodulator input pin b
  output wire        short_wave_out_o,  // Short timer waveform
  output wire        long_wave_out_o,   // Long timer waveform
  output wire        combined_out_o,    // Combined waveform pin
  output wire        long_pin_out_o,    // Long waveform on its pin
  output wire        short_irq_o,       // Short timer interrupt request
  output wire        long_irq_o         // Long timer interrupt request
);

  // Short timer control
  reg        en8;      // Short enable
  reg        single8;  // Short single pass
  reg        to8;      // Short time-out flag
  reg [1:0]  clk8;     // Short prescale select
  reg        capm8;    // Short capture interrupt mask
  reg        tom8;     // Short time-out interrupt mask
  reg        comb_en;  // Combined output onto its pin
  // Shared control
  reg        mode;     // Demodulation when set
  reg        pin_sel;  // Input pin b when set
  reg [1:0]  esel;     // Edge kind or output logic
  reg [1:0]  sub;      // Submode or filter width
  reg        init8;    // Short initial level
  reg        init16;   // Long initial level
  reg        rise_f;   // Rising edge captured flag
  reg        fall_f;   // Falling edge captured flag
  // Long timer control
  reg        en16;     // Long enable
  reg        single16; // Single pass or edge ignore
  reg        to16;     // Long time-out flag
  reg [1:0]  clk16;    // Long prescale select
  reg        capm16;   // Long capture interrupt mask
  reg        tom16;    // Long time-out interrupt mask
  reg        lpin_en;  // Long output onto its pin
  // Data registers and counters
  reg [7:0]  rld8_hi;  // short_reload_high
  reg [7:0]  rld8_lo;  // short_reload_low
  reg [7:0]  rld16_up; // long_reload_upper
  reg [7:0]  rld16_lo; // long_reload_lower
  reg [7:0]  cap8_r;   // short_capture_rise
  reg [7:0]  cap8_f;   // short_capture_fall
  reg [7:0]  cap16_up; // long_capture_upper
  reg [7:0]  cap16_lo; // long_capture_lower
  reg [7:0]  cnt8;     // Short counter
  reg [15:0] cnt16;    // Long counter
  reg        run8;     // Short counting (demod: first edge seen)
  reg        run16;    // Long counting (demod: first edge seen)
  reg        taken16;  // Long edge consumed while ignoring
  reg        out8;     // Short waveform level
  reg        out16;    // Long waveform level
  // Outputs, bus and input path
  reg        sw_q;     // Registered short output
  reg        lw_q;     // Registered long output
  reg        cw_q;     // Registered combined output
  reg        lp_q;     // Registered long pin output
  reg        sirq_q;   // Short interrupt pulse
  reg        lirq_q;   // Long interrupt pulse
  reg        busy;     // Second cycle of a bus access
  reg [7:0]  rdata;    // Read data register
  reg        in_q;     // Registered raw input
  reg        flt;      // Filtered input level
  reg        flt_d;    // Filtered level, one cycle old
  reg [3:0]  fcnt;     // Filter stability count
  reg [2:0]  pre;      // Free-running prescaler
  reg [7:0]  rd_mux;   // Read selection
  reg [3:0]  flim;     // Filter limit for current width

  // Tick for a prescale code: every 1, 2, 4 or 8 clocks
  function tick_of;
    input [1:0] sel;
    input [2:0] p;
    begin
      case (sel)
        2'h0:    tick_of = 1'b1;
        2'h1:    tick_of = p[0];
        2'h2:    tick_of = &p[1:0];
        default: tick_of = &p;
      endcase
    end
  endfunction

  // Bus decode: every access takes two cycles, write lands in the second
  wire       acc   = avs_read_i | avs_write_i;
  wire       wr    = avs_write_i & busy & avs_byteenable_i[0];
  wire [7:0] wd    = avs_writedata_i[7:0];
  wire [5:0] waddr = {avs_address_i[5:2], 2'b00};
  wire       wr0   = wr & (waddr == `PGDT_OFF_SHORT_CTRL);
  wire       wr1   = wr & (waddr == `PGDT_OFF_SHARED_CTRL);
  wire       wr2   = wr & (waddr == `PGDT_OFF_LONG_CTRL);
  assign avs_waitrequest_o = acc & ~busy;
  assign avs_readdata_o    = {24'h00_0000, rdata};

  // Mode decodes
  wire dm    = mode;
  wire pp    = ~dm & (sub == `PGDT_SUB_PPONG);
  wire tick8  = tick_of(clk8, pre);
  wire tick16 = tick_of(clk16, pre);

  // Qualified edges from the filtered input
  wire pos  = flt & ~flt_d;
  wire neg  = ~flt & flt_d;
  wire qpos = dm & pos & (esel != `PGDT_EDGE_FALL);
  wire qneg = dm & neg & (esel != `PGDT_EDGE_RISE);
  wire edge_q = qpos | qneg;

  // Short timer events
  wire at_one8 = (cnt8 == `PGDT_ONE8);
  wire tc8   = ~dm & en8 & run8 & tick8 & at_one8;
  wire full8 = single8 | pp | (out8 != init8);
  wire cap8  = dm & en8 & run8 & edge_q;
  wire dto8  = dm & en8 & run8 & ~edge_q & tick8 & at_one8;
  wire set_to8 = (tc8 & full8) | dto8;

  // Long timer events
  wire at_one16 = (cnt16 == `PGDT_ONE16);
  wire tc16  = ~dm & en16 & run16 & tick16 & at_one16;
  wire acc16 = dm & en16 & edge_q &
               (~run16 | ~single16 | ~taken16);
  wire cap16 = acc16 & run16;
  wire dto16 = dm & en16 & run16 & ~acc16 & tick16 & at_one16;
  wire sto16 = dto8 & single16 & run16 & taken16 & ~acc16;
  wire set_to16 = tc16 | dto16;

  // Starts: software 0 to 1 on enable, or the partner in ping-pong
  wire start8  = (wr0 & wd[`PGDT_B_ENABLE] & ~en8) | (pp & tc16);
  wire start16 = (wr2 & wd[`PGDT_B_ENABLE] & ~en16) | (pp & tc8);
  wire rearm16 = wr2 & wd[`PGDT_B_SINGLE] & ~single16;

  // Combined waveform logic
  reg comb;
  always @* begin
    case (esel)
      `PGDT_LOG_AND: comb = out8 & lw_q;
      `PGDT_LOG_OR:  comb = out8 | lw_q;
      `PGDT_LOG_NOR: comb = ~(out8 | lw_q);
      default:       comb = ~(out8 & lw_q);
    endcase
  end

  // Filter width by code; no filter passes the level at once
  always @* begin
    case (sub)
      2'h1:    flim = `PGDT_FLT_4;
      2'h2:    flim = `PGDT_FLT_8;
      default: flim = `PGDT_FLT_16;
    endcase
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    case (waddr)
      `PGDT_OFF_SHORT_CTRL:
        rd_mux = {en8, single8, to8, clk8, capm8, tom8, comb_en};
      `PGDT_OFF_SHARED_CTRL:
        rd_mux = {mode, pin_sel, esel, sub,
                  dm ? rise_f : init8, dm ? fall_f : init16};
      `PGDT_OFF_LONG_CTRL:
        rd_mux = {en16, single16, to16, clk16, capm16, tom16, lpin_en};
      `PGDT_OFF_SHORT_RLD_HI: rd_mux = rld8_hi;
      `PGDT_OFF_SHORT_RLD_LO: rd_mux = rld8_lo;
      `PGDT_OFF_LONG_RLD_UP:  rd_mux = rld16_up;
      `PGDT_OFF_LONG_RLD_LO:  rd_mux = rld16_lo;
      `PGDT_OFF_SHORT_CAP_R:  rd_mux = cap8_r;
      `PGDT_OFF_SHORT_CAP_F:  rd_mux = cap8_f;
      `PGDT_OFF_LONG_CAP_UP:  rd_mux = cap16_up;
      `PGDT_OFF_LONG_CAP_LO:  rd_mux = cap16_lo;
      default:                rd_mux = `PGDT_RST8;
    endcase
  end

  // Input path: pin select, glitch filter, edge history
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_q  <= 1'b0;
      flt   <= 1'b0;
      flt_d <= 1'b0;
      fcnt  <= 4'h0;
      pre   <= 3'h0;
    end else begin
      pre   <= pre + 3'h1;
      in_q  <= pin_sel ? input_pin_b_i : input_pin_a_i;
      flt_d <= flt;
      if (in_q == flt) begin
        fcnt <= 4'h0;                                  // Glitch ended early
      end else if (sub == 2'h0 || fcnt == flim) begin
        flt  <= in_q;
        fcnt <= 4'h0;
      end else begin
        fcnt <= fcnt + 4'h1;
      end
    end
  end

  // Bus handshake, read data and output registers
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy   <= 1'b0;
      rdata  <= `PGDT_RST8;
      sw_q   <= 1'b0;
      lw_q   <= 1'b0;
      cw_q   <= 1'b0;
      lp_q   <= 1'b0;
      sirq_q <= 1'b0;
      lirq_q <= 1'b0;
    end else begin
      busy <= acc & ~busy;
      if (avs_read_i & ~busy) begin
        rdata <= rd_mux;                               // Stands in 2nd cycle
      end
      sw_q <= out8;
      // Force codes override the long waveform whether enabled or not
      if (~dm & sub[1]) begin
        lw_q <= sub[0];
      end else begin
        lw_q <= out16;
      end
      cw_q   <= comb_en & ~dm & comb;
      lp_q   <= lpin_en & lw_q;
      sirq_q <= (set_to8 & tom8) | (cap8 & capm8);
      lirq_q <= (set_to16 & tom16) | ((cap16 | sto16) & capm16);
    end
  end

  // Control, reload, capture and counter state. Software writes come
  // first so that a hardware set in the same cycle wins over a clear.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en8 <= 1'b0;  single8 <= 1'b0;  to8 <= 1'b0;  clk8 <= 2'h0;
      capm8 <= 1'b0;  tom8 <= 1'b0;  comb_en <= 1'b0;
      mode <= 1'b0;  pin_sel <= 1'b0;  esel <= 2'h0;  sub <= 2'h0;
      init8 <= 1'b0;  init16 <= 1'b0;  rise_f <= 1'b0;  fall_f <= 1'b0;
      en16 <= 1'b0;  single16 <= 1'b0;  to16 <= 1'b0;  clk16 <= 2'h0;
      capm16 <= 1'b0;  tom16 <= 1'b0;  lpin_en <= 1'b0;
      rld8_hi <= `PGDT_RST8;  rld8_lo <= `PGDT_RST8;
      rld16_up <= `PGDT_RST8;  rld16_lo <= `PGDT_RST8;
      cap8_r <= `PGDT_RST8;  cap8_f <= `PGDT_RST8;
      cap16_up <= `PGDT_RST8;  cap16_lo <= `PGDT_RST8;
      cnt8 <= `PGDT_RST8;  cnt16 <= `PGDT_RST16;
      run8 <= 1'b0;  run16 <= 1'b0;  taken16 <= 1'b0;
      out8 <= 1'b0;  out16 <= 1'b0;
    end else begin
      // Software: control fields; enable 0 stops at once
      if (wr0) begin
        en8     <= wd[`PGDT_B_ENABLE];
        single8 <= wd[`PGDT_B_SINGLE];
        clk8    <= wd[`PGDT_B_CLK_HI:`PGDT_B_CLK_LO];
        capm8   <= wd[`PGDT_B_CAP_MASK];
        tom8    <= wd[`PGDT_B_TO_MASK];
        comb_en <= wd[`PGDT_B_PIN_EN];
        if (wd[`PGDT_B_TIMEOUT]) to8 <= 1'b0;
        if (~wd[`PGDT_B_ENABLE]) run8 <= 1'b0;
      end
      if (wr1) begin
        mode    <= wd[`PGDT_B_MODE];
        pin_sel <= wd[`PGDT_B_PIN_SEL];
        esel    <= wd[`PGDT_B_EDGE_HI:`PGDT_B_EDGE_LO];
        sub     <= wd[`PGDT_B_SUB_HI:`PGDT_B_SUB_LO];
        if (dm) begin
          if (wd[`PGDT_B_INIT8])  rise_f <= 1'b0;
          if (wd[`PGDT_B_INIT16]) fall_f <= 1'b0;
        end else begin
          init8  <= wd[`PGDT_B_INIT8];
          init16 <= wd[`PGDT_B_INIT16];
        end
      end
      if (wr2) begin
        en16     <= wd[`PGDT_B_ENABLE];
        single16 <= wd[`PGDT_B_SINGLE];
        clk16    <= wd[`PGDT_B_CLK_HI:`PGDT_B_CLK_LO];
        capm16   <= wd[`PGDT_B_CAP_MASK];
        tom16    <= wd[`PGDT_B_TO_MASK];
        lpin_en  <= wd[`PGDT_B_PIN_EN];
        if (wd[`PGDT_B_TIMEOUT]) to16 <= 1'b0;
        if (~wd[`PGDT_B_ENABLE]) run16 <= 1'b0;
        if (rearm16) taken16 <= 1'b0;
      end
      // Reload values are only latched here; counters read them at loads
      if (wr & waddr == `PGDT_OFF_SHORT_RLD_HI) rld8_hi  <= wd;
      if (wr & waddr == `PGDT_OFF_SHORT_RLD_LO) rld8_lo  <= wd;
      if (wr & waddr == `PGDT_OFF_LONG_RLD_UP)  rld16_up <= wd;
      if (wr & waddr == `PGDT_OFF_LONG_RLD_LO)  rld16_lo <= wd;

      // Idle transmit outputs rest at the inverse of the initial level
      if (~dm & ~en8)  out8  <= ~init8;
      if (~dm & ~en16) out16 <= ~init16;

      // Short timer
      if (start8) begin
        en8 <= 1'b1;
        run8 <= ~dm;
        if (~dm) begin
          out8 <= init8;
          cnt8 <= init8 ? rld8_hi : rld8_lo;
        end
      end else if (tc8) begin
        out8 <= ~out8;
        if (single8 | pp) begin
          en8  <= 1'b0;
          run8 <= 1'b0;
          cnt8 <= cnt8 - `PGDT_ONE8;
        end else begin
          cnt8 <= out8 ? rld8_lo : rld8_hi;
        end
      end else if (dm & en8 & edge_q) begin
        if (run8) begin
          if (qpos) cap8_r <= ~cnt8;
          else      cap8_f <= ~cnt8;
          cnt8 <= `PGDT_ONES8;
        end else begin
          run8 <= 1'b1;
          cnt8 <= rld8_lo;
        end
      end else if (en8 & run8 & tick8) begin
        cnt8 <= cnt8 - `PGDT_ONE8;
      end
      if (set_to8) to8 <= 1'b1;

      // Long timer
      if (start16) begin
        en16 <= 1'b1;
        run16 <= ~dm;
        taken16 <= 1'b0;
        if (~dm) begin
          out16 <= init16;
          cnt16 <= {rld16_up, rld16_lo};
        end
      end else if (tc16) begin
        out16 <= ~out16;
        if (single16 | pp) begin
          en16  <= 1'b0;
          run16 <= 1'b0;
          cnt16 <= cnt16 - `PGDT_ONE16;
        end else begin
          cnt16 <= {rld16_up, rld16_lo};
        end
      end else if (acc16) begin
        {cap16_up, cap16_lo} <= ~cnt16;
        taken16 <= 1'b1;
        run16 <= 1'b1;
        if (run16) begin
          cnt16 <= `PGDT_ONES16;
        end else begin
          cnt16 <= {rld16_up, rld16_lo};
        end
      end else if (en16 & run16 & tick16) begin
        cnt16 <= cnt16 - `PGDT_ONE16;
      end
      if (sto16) {cap16_up, cap16_lo} <= ~cnt16;
      if (set_to16) to16 <= 1'b1;

      // Edge flags from either capture
      if ((cap8 | cap16) & qpos) rise_f <= 1'b1;
      if ((cap8 | cap16) & qneg) fall_f <= 1'b1;
    end
  end

  assign short_wave_out_o = sw_q;
  assign long_wave_out_o  = lw_q;
  assign combined_out_o   = cw_q;
  assign long_pin_out_o   = lp_q;
  assign short_irq_o      = sirq_q;
  assign long_irq_o       = lirq_q;

endmodule

/* File: test/pgdt_timers_properties.sv */
// Port-level checker for the timer pair, bound to its top module
`timescale 1ns/1ps
module pgdt_timers_props (
  input wire        clk_i,             // System clock
  input wire        resetn_i,          // Reset, active low
  input wire [5:0]  avs_address_i,     // Bus byte address
  input wire        avs_read_i,        // Bus read strobe
  input wire        avs_write_i,       // Bus write strobe
  input wire [31:0] avs_writedata_i,   // Bus write data
  input wire [3:0]  avs_byteenable_i,  // Bus lane enables
  input wire        avs_waitrequest_o, // Bus stall
  input wire        long_wave_out_o,   // Long waveform
  input wire        short_irq_o,       // Short interrupt pulse
  input wire        long_irq_o         // Long interrupt pulse
);
  // A write lands at the edge where the stall is seen low
  wire       wr_ok = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  wire [3:0] word  = avs_address_i[5:2];   // Register index
  reg  [1:0] msk8;                         // Short capture/time-out masks
  reg  [1:0] msk16;                        // Long capture/time-out masks
  reg  [2:0] cyc;                          // Edges since reset, saturating

  // Shadow the mask bits; hardware never changes them itself
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      msk8  <= 2'h0;
      msk16 <= 2'h0;
      cyc   <= 3'h0;
    end else begin
      cyc <= (cyc == 3'h7) ? cyc : cyc + 3'h1;
      if (wr_ok && word == 4'h0)
        msk8 <= avs_writedata_i[2:1];
      if (wr_ok && word == 4'h2)
        msk16 <= avs_writedata_i[2:1];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_wait_one;
    (avs_read_i | avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus stall longer than one cycle");
  property p_irq8_pulse;
    short_irq_o |=> !short_irq_o;
  endproperty
  a_irq8_pulse: assert property (p_irq8_pulse)
    else $error("short interrupt longer than one cycle");
  property p_irq16_pulse;
    long_irq_o |=> !long_irq_o;
  endproperty
  a_irq16_pulse: assert property (p_irq16_pulse)
    else $error("long interrupt longer than one cycle");
  property p_irq8_mask;
    short_irq_o |-> msk8 != 2'h0;
  endproperty
  a_irq8_mask: assert property (p_irq8_mask)
    else $error("short interrupt while masked");
  property p_irq16_mask;
    long_irq_o |-> msk16 != 2'h0;
  endproperty
  a_irq16_mask: assert property (p_irq16_mask)
    else $error("long interrupt while masked");
  property p_force0;
    wr_ok && word == 4'h1 && !avs_writedata_i[7]
      && avs_writedata_i[3:2] == 2'h2 |-> ##[1:3] !long_wave_out_o;
  endproperty
  a_force0: assert property (p_force0)
    else $error("long output not forced low");
  property p_force1;
    wr_ok && word == 4'h1 && !avs_writedata_i[7]
      && avs_writedata_i[3:2] == 2'h3 |-> ##[1:3] long_wave_out_o;
  endproperty
  a_force1: assert property (p_force1)
    else $error("long output not forced high");
  property p_idle_long;
    cyc == 3'h3 |-> long_wave_out_o;
  endproperty
  a_idle_long: assert property (p_idle_long)
    else $error("idle long output not inverse of initial level");
endmodule

bind pgdt_timers pgdt_timers_props u_props (
  .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .long_wave_out_o(long_wave_out_o),
  .short_irq_o(short_irq_o), .long_irq_o(long_irq_o));

/* File: test/pgdt_pulse_src.sv */
// Remote pulse emitter feeding the two demodulator input pins
`timescale 1ns/1ps
module pgdt_pulse_src (
  input  wire       clk_i,     // System clock
  input  wire       start_i,   // Starts one burst
  input  wire       pin_sel_i, // Burst on pin b when set, else pin a
  input  wire [7:0] gap_i,     // Cycles between like edges
  output wire       pin_a_o,   // Line to pin a
  output wire       pin_b_o    // Line to pin b
);
  reg  [8:0] cnt = 9'h000;              // Cycles into burst, 0 idle
  wire [8:0] g   = {1'b0, gap_i};       // Edge spacing
  wire [8:0] h   = {2'b00, gap_i[7:1]}; // High phase, half the gap
  // Two high phases one gap apart; a short gap makes a glitch
  wire lvl = cnt != 9'h000 && (cnt <= h || (cnt > g && cnt <= g + h));
  // Burst counter; the line rests low between bursts, as if pulled down
  always @(posedge clk_i) begin
    if (start_i)
      cnt <= 9'h001;
    else if (cnt != 9'h000)
      cnt <= (cnt > g + h) ? 9'h000 : cnt + 9'h001;
  end
  assign pin_a_o = lvl & ~pin_sel_i;
  assign pin_b_o = lvl & pin_sel_i;
endmodule

/* File: test/pgdt_timers_test.sv */
// Register-level tests of the timer pair
`timescale 1ns/1ps
`include "pgdt_map.vh"
module pgdt_timers_test;
  logic        clk_i, resetn_i, go, psel; // Clock, reset, burst controls
  logic        avs_read_i, avs_write_i;   // Bus strobes
  logic [5:0]  avs_address_i;             // Bus address
  logic [31:0] avs_writedata_i;           // Bus write data
  logic [3:0]  avs_byteenable_i;          // Bus lanes
  logic [7:0]  gap, q, sh;                // Burst gap, read byte, setup
  wire  [31:0] avs_readdata_o;            // Bus read data
  wire         avs_waitrequest_o;         // Bus stall
  wire         pa, pb, sw, lw, cw, lp, sirq, lirq; // Pins, waves, interrupts
  integer      error_cnt, total_checks, n; // Counters

  pgdt_timers uut (.clk_i(clk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .input_pin_a_i(pa),
    .input_pin_b_i(pb), .short_wave_out_o(sw), .long_wave_out_o(lw),
    .combined_out_o(cw), .long_pin_out_o(lp), .short_irq_o(sirq),
    .long_irq_o(lirq));
  pgdt_pulse_src src (.clk_i(clk_i), .start_i(go), .pin_sel_i(psel),
    .gap_i(gap), .pin_a_o(pa), .pin_b_o(pb));

  // Count and report one comparison
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    begin
      total_checks++;
      if (s !== e) begin
        error_cnt++;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task ok(input string nm, input logic c);
    chk(nm, {7'h00, c}, 8'h01);
  endtask
  // One access, held until the stall is seen low at a rising edge
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    integer t;
    begin
      t = 0;
      @(posedge clk_i);
      avs_address_i   <= a;
      avs_writedata_i <= {24'h00_0000, d};
      avs_write_i     <= w;
      avs_read_i      <= ~w;
      do begin
        @(negedge clk_i);
        t++;
      end while (avs_waitrequest_o !== 1'b0 && t < 50);
      @(posedge clk_i);
      q = avs_readdata_o[7:0];
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      ok("bus answer", t < 50);
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rc(input logic [5:0] a, input logic [7:0] e, input string nm);
    begin
      bus(1'b0, a, 8'h00);
      chk(nm, q, e);
    end
  endtask
  // Wait, bounded, for an interrupt pulse; n is the cycles spent
  task wirq(input logic lng);
    begin
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while ((lng ? lirq : sirq) !== 1'b1 && n < 600);
      ok("irq seen", n < 600);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // Free-running 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Hang guard, well beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    results;
  end

  initial begin
    {resetn_i, go, psel, avs_read_i, avs_write_i} = 5'h00;
    {avs_address_i, avs_writedata_i, gap, error_cnt, total_checks} = 0;
    avs_byteenable_i = 4'hF;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    // Reset values, an unmapped word and a write with its lane off
    for (int a = 0; a < 48; a += 4)
      rc(a[5:0], 8'h00, "reset value");
    wr(6'h2C, 8'hFF);
    rc(6'h2C, 8'h00, "unmapped");
    avs_byteenable_i <= 4'h0;
    wr(`PGDT_OFF_SHORT_RLD_HI, 8'h55);
    avs_byteenable_i <= 4'hF;
    rc(`PGDT_OFF_SHORT_RLD_HI, 8'h00, "lane off");
    $display("register access done");
    // Short single pass from the high reload, initial level 1
    wr(`PGDT_OFF_SHARED_CTRL, 8'h02);
    wr(`PGDT_OFF_SHORT_RLD_HI, 8'h03);
    wr(`PGDT_OFF_SHORT_RLD_LO, 8'h40);
    wr(`PGDT_OFF_SHORT_CTRL, 8'hCA);
    repeat (2) @(negedge clk_i);
    ok("short start level", sw);
    wirq(1'b0);
    ok("short reload pick", n < 12);
    @(negedge clk_i);
    ok("short end level", ~sw);
    rc(`PGDT_OFF_SHORT_CTRL, 8'h6A, "short stop flag");
    wr(`PGDT_OFF_SHORT_CTRL, 8'h4A);
    rc(`PGDT_OFF_SHORT_CTRL, 8'h6A, "zero kept flag");
    wr(`PGDT_OFF_SHORT_CTRL, 8'h6B);
    rc(`PGDT_OFF_SHORT_CTRL, 8'h4B, "one cleared flag");
    $display("short single pass done");
    // Long single pass of 1*256+2 ticks, initial level 1
    wr(`PGDT_OFF_SHARED_CTRL, 8'h01);
    repeat (4) @(negedge clk_i);
    ok("long idle level", ~lw);
    wr(`PGDT_OFF_LONG_RLD_UP, 8'h01);
    wr(`PGDT_OFF_LONG_RLD_LO, 8'h02);
    wr(`PGDT_OFF_LONG_CTRL, 8'hC2);
    repeat (3) @(negedge clk_i);
    ok("long start level", lw);
    wirq(1'b1);
    ok("long length", n >= 248 && n <= 262);
    @(negedge clk_i);
    ok("long end level", ~lw);
    rc(`PGDT_OFF_LONG_CTRL, 8'h62, "long stop flag");
    wr(`PGDT_OFF_LONG_CTRL, 8'h21);
    rc(`PGDT_OFF_LONG_CTRL, 8'h01, "long flag clear");
    // Force codes override the idle long output
    wr(`PGDT_OFF_SHARED_CTRL, 8'h0D);
    repeat (4) @(negedge clk_i);
    ok("force high", lw & lp & cw);
    wr(`PGDT_OFF_SHARED_CTRL, 8'h08);
    repeat (4) @(negedge clk_i);
    ok("force low", ~(lw | lp | cw));
    wr(`PGDT_OFF_SHARED_CTRL, 8'h00);
    $display("long and force done");
    // Modulo-N: one interrupt per low plus high phase (2 + 5 ticks)
    wr(`PGDT_OFF_SHORT_RLD_LO, 8'h02);
    wr(`PGDT_OFF_SHORT_RLD_HI, 8'h05);
    wr(`PGDT_OFF_SHORT_CTRL, 8'h82);
    wirq(1'b0);
    wirq(1'b0);
    ok("modulo period", n >= 6 && n <= 9);
    wr(`PGDT_OFF_SHORT_CTRL, 8'h02);
    wr(`PGDT_OFF_SHORT_CTRL, 8'h22);
    // Ping-pong: timers hand over at each terminal count
    wr(`PGDT_OFF_LONG_RLD_UP, 8'h00);
    wr(`PGDT_OFF_LONG_RLD_LO, 8'h04);
    wr(`PGDT_OFF_LONG_CTRL, 8'h4A);
    wr(`PGDT_OFF_SHARED_CTRL, 8'h04);
    wr(`PGDT_OFF_SHORT_CTRL, 8'hCA);
    wirq(1'b0);
    wirq(1'b1);
    wirq(1'b0);
    rc(`PGDT_OFF_SHORT_CTRL, 8'h6A, "pingpong short");
    ok("pingpong flag", q[5]);
    wr(`PGDT_OFF_SHARED_CTRL, 8'h00);
    repeat (40) @(negedge clk_i);
    rc(`PGDT_OFF_SHORT_CTRL, 8'h6A, "pingpong end short");
    ok("pingpong short off", ~q[7]);
    rc(`PGDT_OFF_LONG_CTRL, 8'h6A, "pingpong end long");
    ok("pingpong long off", ~q[7]);
    wr(`PGDT_OFF_SHORT_CTRL, 8'h20);
    wr(`PGDT_OFF_LONG_CTRL, 8'h20);
    $display("modulo and pingpong done");
    // Demod: rise on pin a, fall on filtered pin b, then a glitch
    wr(`PGDT_OFF_SHORT_RLD_HI, 8'hFF);
    wr(`PGDT_OFF_SHORT_RLD_LO, 8'hFF);
    for (int k = 0; k < 3; k++) begin
      sh = (k == 0) ? 8'h80 : 8'hDC;
      wr(`PGDT_OFF_SHARED_CTRL, sh);
      wr(`PGDT_OFF_SHORT_CTRL, 8'h84);
      psel <= (k != 0);
      gap  <= (k == 2) ? 8'h08 : 8'h28;
      go   <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      if (k == 2) begin
        repeat (120) @(negedge clk_i);
        rc(`PGDT_OFF_SHARED_CTRL, sh, "glitch removed");
      end else begin
        wirq(1'b0);
        rc(k ? `PGDT_OFF_SHORT_CAP_F : `PGDT_OFF_SHORT_CAP_R, 8'h27, "cap");
        ok("capture width", q >= 8'h27 && q <= 8'h29);
        sh = sh | (k ? 8'h01 : 8'h02);
        rc(`PGDT_OFF_SHARED_CTRL, sh, "edge flag");
        wr(`PGDT_OFF_SHARED_CTRL, sh);
        rc(`PGDT_OFF_SHARED_CTRL, sh & 8'hFC, "edge flag clear");
      end
      wr(`PGDT_OFF_SHORT_CTRL, 8'h00);
    end
    $display("demodulation done");
    results;
  end
endmodule
